// ==== include/pflow_pkg.sv ====
package pflow_pkg;

   // ----------------------------------------------------------------
   // input register numbers
   // ----------------------------------------------------------------
   localparam logic [15:0] REG_DIFF_PRESSURE = 16'h0001;
   localparam logic [15:0] REG_FLOW_HIGH = 16'h0002;
   localparam logic [15:0] REG_FLOW_LOW = 16'h0003;
   localparam logic [15:0] REG_AIR_VELOCITY = 16'h0004;
   localparam logic [15:0] REG_OUTPUT = 16'h0005;
   localparam logic [15:0] REG_MAX_FLOW_HIGH = 16'h0006;
   localparam logic [15:0] REG_MAX_FLOW_LOW = 16'h0007;
   localparam logic [15:0] REG_SPAN_FLAG = 16'h0008;
   localparam logic [15:0] REG_ALARM_FLAG = 16'h0009;
   localparam logic [15:0] REG_FEEDBACK_LOST = 16'h000A;
   localparam logic [15:0] REG_SENSOR_FAULT = 16'h000B;
   localparam logic [15:0] REG_RSVD_FIRST = 16'h000C;
   localparam logic [15:0] REG_RSVD_LAST = 16'h0014;

   // ----------------------------------------------------------------
   // value ranges and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] VELOCITY_MAX = 16'h012C;
   localparam logic [15:0] OUTPUT_MAX = 16'h03E8;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [31:0] FLOW_RESET = 32'h0000_0000;
   localparam int FULL_SCALE_PA_DEFAULT = 1000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_HALF_MS;
   localparam int BLINK_W = 24;
   localparam int SQRT_STEPS = 8;

   // integer square root, floor
   function automatic logic [7:0] isqrt16(input logic [15:0] v);
      logic [7:0] r;
      logic [7:0] t;
      r = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         t = r | (8'h01 << i);
         if (({8'h00, t} * {8'h00, t}) <= v) begin
            r = t;
         end
      end
      return r;
   endfunction

endpackage

// ==== hdl/sqrt_unit.sv ====
`timescale 1ns/1ns
module sqrt_unit (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [15:0] value,
   output logic busy,
   output logic done,
   output logic [7:0] root
);

   typedef enum logic {SQ_IDLE, SQ_RUN} sq_state_e;

   typedef struct packed {
      sq_state_e state;
      logic [15:0] val;
      logic [7:0] root;
      logic [2:0] idx;
      logic done;
   } sq_s;

   sq_s st;
   sq_s next_st;
   logic [7:0] trial;

   // ----------------------------------------------------------------
   // one result bit per cycle, msb first
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      trial = st.root | (8'h01 << st.idx);
      case (st.state)
         SQ_IDLE: begin
            if (start) begin
               next_st.state = SQ_RUN;
               next_st.val = value;
               next_st.root = 8'h00;
               next_st.idx = 3'h7;
            end
         end
         SQ_RUN: begin
            if (({8'h00, trial} * {8'h00, trial}) <= st.val) begin
               next_st.root = trial;
            end
            if (st.idx == 3'h0) begin
               next_st.state = SQ_IDLE;
               next_st.done = 1'b1;
            end else begin
               next_st.idx = st.idx - 3'h1;
            end
         end
         default: begin
            next_st.state = SQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{SQ_IDLE, 16'h0000, 8'h00, 3'h0, 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign busy = (st.state == SQ_RUN);
   assign done = st.done;
   assign root = st.root;

   root_floor_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      done |-> (({8'h00, root} * {8'h00, root}) <= st.val) &&
               (({8'h00, root} + 16'h0001) * ({8'h00, root} + 16'h0001) > {16'h0000, st.val}))
      else $error("square root result not the floor");

endmodule

// ==== hdl/pressure_flow_input_registers.sv ====
`timescale 1ns/1ns
// How it works
// - flow reported in whole cubic metres per hour
// - flow high word reg 2, low reg 3
// - flow is coefficient times root of pressure
// - zero coefficient: area times velocity, velocity enabled
// - velocity only when enabled, clamped 0 to 300
// - output percentage clamped 0 to 1000
// - maximum flow reported as two words
// - span flag set outside span limits
// - alarm flag set outside alarm limits
// - auto tune forces both flags inactive
// - feedback lost flag, red indicator flashes
// - sensor fault flag, red indicator flashes
module pressure_flow_input_registers #(
   parameter int BLINK_CYCLES = pflow_pkg::BLINK_CYCLES,
   parameter int FULL_SCALE_PA = pflow_pkg::FULL_SCALE_PA_DEFAULT
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic rd_req,
   input wire logic [15:0] rd_addr,
   output logic rd_valid,
   output logic rd_err,
   output logic [15:0] rd_data,
   input wire logic wr_req,
   input wire logic [15:0] wr_addr,
   output logic wr_refused,
   input wire logic signed [15:0] pressure_pa,
   input wire logic [15:0] velocity_raw,
   input wire logic [15:0] output_raw,
   input wire logic [15:0] flow_coeff,
   input wire logic [15:0] duct_area,
   input wire logic velocity_enable,
   input wire logic autotune_active,
   input wire logic signed [15:0] pres_span_lo,
   input wire logic signed [15:0] pres_span_hi,
   input wire logic signed [15:0] pres_alarm_lo,
   input wire logic signed [15:0] pres_alarm_hi,
   input wire logic [15:0] flow_span_lo,
   input wire logic [15:0] flow_span_hi,
   input wire logic [15:0] flow_alarm_lo,
   input wire logic [15:0] flow_alarm_hi,
   input wire logic [15:0] vel_span_lo,
   input wire logic [15:0] vel_span_hi,
   input wire logic [15:0] vel_alarm_lo,
   input wire logic [15:0] vel_alarm_hi,
   input wire logic feedback_lost_pin,
   input wire logic sensor_fault_pin,
   output logic red_led
);

   localparam logic [7:0] FULL_SCALE_ROOT = pflow_pkg::isqrt16(FULL_SCALE_PA[15:0]);
   localparam logic [pflow_pkg::BLINK_W-1:0] BLINK_LAST = BLINK_CYCLES[pflow_pkg::BLINK_W-1:0] - 1'b1;

   typedef struct packed {
      logic fb_s1;
      logic fb_s2;
      logic sf_s1;
      logic sf_s2;
      logic sq_start;
      logic [31:0] flow;
      logic [31:0] max_flow;
      logic [15:0] vel;
      logic [15:0] outp;
      logic span;
      logic alarm;
      logic fb;
      logic sf;
      logic [pflow_pkg::BLINK_W-1:0] blink_cnt;
      logic blink;
      logic rd_valid;
      logic rd_err;
      logic wr_refused;
      logic [15:0] rd_data;
   } state_s;

   state_s st;
   state_s next_st;
   logic sq_busy;
   logic sq_done;
   logic [7:0] sq_root;
   logic [15:0] sq_value;
   logic [15:0] vel_clamped;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic out_u(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
      return (v < {16'h0000, lo}) || (v > {16'h0000, hi});
   endfunction

   function automatic logic out_s(input logic signed [15:0] v, input logic signed [15:0] lo,
                                  input logic signed [15:0] hi);
      return (v < lo) || (v > hi);
   endfunction

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] top);
      return (v > top) ? top : v;
   endfunction

   // negative pressure has no real root; flow treats it as zero
   assign sq_value = pressure_pa[15] ? 16'h0000 : pressure_pa;
   assign vel_clamped = clamp(velocity_raw, pflow_pkg::VELOCITY_MAX);

   sqrt_unit u_sqrt (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .start(st.sq_start),
      .value(sq_value),
      .busy(sq_busy),
      .done(sq_done),
      .root(sq_root)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.fb_s1 = feedback_lost_pin;
      next_st.fb_s2 = st.fb_s1;
      next_st.sf_s1 = sensor_fault_pin;
      next_st.sf_s2 = st.sf_s1;
      next_st.fb = st.fb_s2;
      next_st.sf = st.sf_s2;
      // restart the root as soon as the unit is free, so flow tracks pressure
      next_st.sq_start = !sq_busy && !st.sq_start && !sq_done;

      if (sq_done) begin
         if (flow_coeff != 16'h0000) begin
            next_st.flow = {16'h0000, flow_coeff} * {24'h000000, sq_root};
         end else if (velocity_enable) begin
            next_st.flow = {16'h0000, duct_area} * {16'h0000, vel_clamped};
         end else begin
            next_st.flow = pflow_pkg::FLOW_RESET;
         end
      end

      if (flow_coeff != 16'h0000) begin
         next_st.max_flow = {16'h0000, flow_coeff} * {24'h000000, FULL_SCALE_ROOT};
      end else begin
         next_st.max_flow = {16'h0000, duct_area} * {16'h0000, pflow_pkg::VELOCITY_MAX};
      end

      next_st.vel = velocity_enable ? vel_clamped : pflow_pkg::WORD_RESET;
      next_st.outp = clamp(output_raw, pflow_pkg::OUTPUT_MAX);

      next_st.span = !autotune_active &&
                     (out_s(pressure_pa, pres_span_lo, pres_span_hi) ||
                      out_u(st.flow, flow_span_lo, flow_span_hi) ||
                      (velocity_enable && out_u({16'h0000, st.vel}, vel_span_lo, vel_span_hi)));
      next_st.alarm = !autotune_active &&
                      (out_s(pressure_pa, pres_alarm_lo, pres_alarm_hi) ||
                       out_u(st.flow, flow_alarm_lo, flow_alarm_hi) ||
                       (velocity_enable && out_u({16'h0000, st.vel}, vel_alarm_lo, vel_alarm_hi)));

      if (st.blink_cnt >= BLINK_LAST) begin
         next_st.blink_cnt = '0;
         next_st.blink = !st.blink;
      end else begin
         next_st.blink_cnt = st.blink_cnt + 1'b1;
      end

      // ----------------------------------------------------------------
      // register read; writes are never taken
      // ----------------------------------------------------------------
      next_st.rd_valid = rd_req;
      next_st.rd_err = 1'b0;
      next_st.wr_refused = wr_req && !rd_req;
      if (rd_req) begin
         next_st.rd_data = pflow_pkg::WORD_RESET;
         case (rd_addr)
            pflow_pkg::REG_DIFF_PRESSURE: next_st.rd_data = pressure_pa;
            pflow_pkg::REG_FLOW_HIGH: next_st.rd_data = st.flow[31:16];
            pflow_pkg::REG_FLOW_LOW: next_st.rd_data = st.flow[15:0];
            pflow_pkg::REG_AIR_VELOCITY: next_st.rd_data = st.vel;
            pflow_pkg::REG_OUTPUT: next_st.rd_data = st.outp;
            pflow_pkg::REG_MAX_FLOW_HIGH: next_st.rd_data = st.max_flow[31:16];
            pflow_pkg::REG_MAX_FLOW_LOW: next_st.rd_data = st.max_flow[15:0];
            pflow_pkg::REG_SPAN_FLAG: next_st.rd_data = {15'h0000, st.span};
            pflow_pkg::REG_ALARM_FLAG: next_st.rd_data = {15'h0000, st.alarm};
            pflow_pkg::REG_FEEDBACK_LOST: next_st.rd_data = {15'h0000, st.fb};
            pflow_pkg::REG_SENSOR_FAULT: next_st.rd_data = {15'h0000, st.sf};
            default: begin
               // reserved range reads zero; anything else is unmapped
               if (rd_addr < pflow_pkg::REG_RSVD_FIRST || rd_addr > pflow_pkg::REG_RSVD_LAST) begin
                  next_st.rd_err = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rd_valid = st.rd_valid;
   assign rd_err = st.rd_err;
   assign rd_data = st.rd_data;
   assign wr_refused = st.wr_refused;
   // one indicator shared by both faults, as a user sees a single red lamp
   assign red_led = (st.fb || st.sf) && st.blink;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence fb_held_s;
      feedback_lost_pin [*3];
   endsequence

   sequence sf_held_s;
      sensor_fault_pin [*3];
   endsequence

   read_latency_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      rd_req |=> rd_valid ##1 (!rd_valid || $past(rd_req)))
      else $error("read answer not one cycle later");

   rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (rd_req && rd_addr >= pflow_pkg::REG_RSVD_FIRST && rd_addr <= pflow_pkg::REG_RSVD_LAST)
      |=> rd_valid && !rd_err && rd_data == 16'h0000)
      else $error("reserved register not zero");

   write_refused_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (wr_req && !rd_req) |=> wr_refused && !rd_valid)
      else $error("write not refused");

   flow_split_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (rd_req && rd_addr == pflow_pkg::REG_FLOW_HIGH) |=> rd_data == $past(st.flow[31:16]))
      else $error("flow high word wrong");

   pressure_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (rd_req && rd_addr == pflow_pkg::REG_DIFF_PRESSURE) |=> rd_data == $past(pressure_pa))
      else $error("pressure read wrong");

   coeff_flow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (sq_done && flow_coeff != 16'h0000)
      |=> st.flow == ({16'h0000, $past(flow_coeff)} * {24'h000000, $past(sq_root)}))
      else $error("coefficient flow wrong");

   area_flow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (sq_done && flow_coeff == 16'h0000)
      |=> st.flow == ($past(velocity_enable) ? ({16'h0000, $past(duct_area)} * {16'h0000, $past(vel_clamped)})
                      : 32'h0000_0000))
      else $error("area flow wrong");

   velocity_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !velocity_enable |=> st.vel == 16'h0000 ##1 st.vel <= pflow_pkg::VELOCITY_MAX)
      else $error("velocity not gated");

   output_clamp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (output_raw > pflow_pkg::OUTPUT_MAX) |=> st.outp == pflow_pkg::OUTPUT_MAX)
      else $error("output not clamped");

   span_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!autotune_active && pressure_pa > pres_span_hi) |=> st.span)
      else $error("span flag not set");

   alarm_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!autotune_active && pressure_pa < pres_alarm_lo) |=> st.alarm)
      else $error("alarm flag not set");

   tune_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      autotune_active |=> !st.span && !st.alarm)
      else $error("flags active during auto tune");

   fb_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      fb_held_s |=> st.fb)
      else $error("feedback lost flag late");

   sf_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      sf_held_s |=> st.sf)
      else $error("sensor fault flag late");

   led_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!st.fb && !st.sf) |-> !red_led)
      else $error("red indicator lit without fault");

endmodule

// ==== bench/master_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// register master: one request at a time, held for one cycle
// ----------------------------------------------------------------
module master_model (
   input wire logic core_clk,
   output logic rd_req,
   output logic [15:0] rd_addr,
   input wire logic rd_valid,
   input wire logic rd_err,
   input wire logic [15:0] rd_data,
   output logic wr_req,
   output logic [15:0] wr_addr,
   input wire logic wr_refused
);
   initial begin
      rd_req = 1'b0;
      rd_addr = 16'hFFFF;
      wr_req = 1'b0;
      wr_addr = 16'hFFFF;
   end

   // idle address is inverted so a stale value is never read as valid
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
      int n;
      n = 0;
      @(posedge core_clk);
      rd_req <= 1'b1;
      rd_addr <= a;
      @(posedge core_clk);
      rd_req <= 1'b0;
      rd_addr <= ~a;
      @(posedge core_clk);
      while (rd_valid !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         n++;
      end
      d = (n < 4) ? rd_data : 16'hxxxx;
      e = (n < 4) ? rd_err : 1'bx;
   endtask

   task automatic wr(input logic [15:0] a, output logic refused);
      @(posedge core_clk);
      wr_req <= 1'b1;
      wr_addr <= a;
      @(posedge core_clk);
      wr_req <= 1'b0;
      wr_addr <= ~a;
      @(posedge core_clk);
      refused = wr_refused;
   endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
   logic core_clk, arst_n;
   logic rd_req, rd_valid, rd_err, wr_req, wr_refused, red_led;
   logic [15:0] rd_addr, rd_data, wr_addr;
   logic signed [15:0] pressure_pa, ps_lo, ps_hi, pa_lo, pa_hi;
   logic [15:0] velocity_raw, output_raw, flow_coeff, duct_area, vs_hi, fs_hi, fa_hi;
   logic velocity_enable, autotune_active, fb_pin, sf_pin;
   int error_cnt = 0;
   int check_count = 0;
   logic [31:0] ef;
   logic ref_seen;
   int toggles;

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   pressure_flow_input_registers #(.BLINK_CYCLES(4)) DUT (
      .core_clk(core_clk), .arst_n(arst_n),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data),
      .wr_req(wr_req), .wr_addr(wr_addr), .wr_refused(wr_refused),
      .pressure_pa(pressure_pa), .velocity_raw(velocity_raw), .output_raw(output_raw),
      .flow_coeff(flow_coeff), .duct_area(duct_area), .velocity_enable(velocity_enable),
      .autotune_active(autotune_active),
      .pres_span_lo(ps_lo), .pres_span_hi(ps_hi), .pres_alarm_lo(pa_lo), .pres_alarm_hi(pa_hi),
      .flow_span_lo(16'h0000), .flow_span_hi(fs_hi), .flow_alarm_lo(16'h0000), .flow_alarm_hi(fa_hi),
      .vel_span_lo(16'h0000), .vel_span_hi(vs_hi), .vel_alarm_lo(16'h0000), .vel_alarm_hi(16'hFFFF),
      .feedback_lost_pin(fb_pin), .sensor_fault_pin(sf_pin), .red_led(red_led)
   );

   master_model host (
      .core_clk(core_clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
      .rd_err(rd_err), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr), .wr_refused(wr_refused)
   );

   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp, input logic exp_err);
      logic [15:0] d;
      logic e;
      host.rd(a, d, e);
      check(d, exp);
      check({15'h0000, e}, {15'h0000, exp_err});
   endtask

   // flow recomputes every ten or so cycles; leave room for two passes
   task automatic settle();
      repeat (40) @(posedge core_clk);
   endtask

   // changes of the red indicator over 24 edges; a flashing lamp changes every 4
   task automatic count_toggles(output int n);
      logic prev;
      n = 0;
      prev = red_led;
      repeat (24) begin
         @(posedge core_clk);
         if (red_led !== prev) n++;
         prev = red_led;
      end
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #400000;
      error_cnt++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      pressure_pa = 16'sh2710;
      velocity_raw = 16'h0000;
      output_raw = 16'h03E8;
      flow_coeff = 16'h1234;
      duct_area = 16'h0007;
      velocity_enable = 1'b0;
      autotune_active = 1'b0;
      ps_lo = -16'sd100;
      ps_hi = 16'sd2000;
      pa_lo = -16'sd500;
      pa_hi = 16'sd5000;
      vs_hi = 16'hFFFF;
      fs_hi = 16'hFFFF;
      fa_hi = 16'hFFFF;
      fb_pin = 1'b0;
      sf_pin = 1'b0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      settle();
      // coefficient path, result spills into the high word
      ef = 32'h0000_1234 * 32'd100;
      rdchk(pflow_pkg::REG_FLOW_HIGH, ef[31:16], 1'b0);
      rdchk(pflow_pkg::REG_FLOW_LOW, ef[15:0], 1'b0);
      ef = 32'h0000_1234 * 32'd31;
      rdchk(pflow_pkg::REG_MAX_FLOW_HIGH, ef[31:16], 1'b0);
      rdchk(pflow_pkg::REG_MAX_FLOW_LOW, ef[15:0], 1'b0);
      rdchk(pflow_pkg::REG_DIFF_PRESSURE, 16'h2710, 1'b0);
      rdchk(pflow_pkg::REG_OUTPUT, 16'h03E8, 1'b0);
      rdchk(pflow_pkg::REG_AIR_VELOCITY, 16'h0000, 1'b0);
      // negative pressure: signed readback, no flow
      @(posedge core_clk);
      pressure_pa <= -16'sd100;
      output_raw <= 16'h04B0;
      settle();
      rdchk(pflow_pkg::REG_DIFF_PRESSURE, 16'hFF9C, 1'b0);
      rdchk(pflow_pkg::REG_FLOW_LOW, 16'h0000, 1'b0);
      rdchk(pflow_pkg::REG_OUTPUT, 16'h03E8, 1'b0);
      // area path with velocity enabled
      @(posedge core_clk);
      pressure_pa <= 16'sd100;
      flow_coeff <= 16'h0000;
      velocity_enable <= 1'b1;
      velocity_raw <= 16'h00FA;
      settle();
      rdchk(pflow_pkg::REG_AIR_VELOCITY, 16'h00FA, 1'b0);
      rdchk(pflow_pkg::REG_FLOW_LOW, 16'd1750, 1'b0);
      rdchk(pflow_pkg::REG_MAX_FLOW_LOW, 16'd2100, 1'b0);
      rdchk(pflow_pkg::REG_SPAN_FLAG, 16'h0000, 1'b0);
      @(posedge core_clk);
      vs_hi <= 16'h00C8;
      settle();
      rdchk(pflow_pkg::REG_SPAN_FLAG, 16'h0001, 1'b0);
      // flow of 1750 against flow limits of 1000
      @(posedge core_clk);
      vs_hi <= 16'hFFFF;
      fs_hi <= 16'd1000;
      fa_hi <= 16'd1000;
      settle();
      rdchk(pflow_pkg::REG_SPAN_FLAG, 16'h0001, 1'b0);
      rdchk(pflow_pkg::REG_ALARM_FLAG, 16'h0001, 1'b0);
      @(posedge core_clk);
      fs_hi <= 16'hFFFF;
      fa_hi <= 16'hFFFF;
      velocity_raw <= 16'h0190;
      settle();
      rdchk(pflow_pkg::REG_AIR_VELOCITY, pflow_pkg::VELOCITY_MAX, 1'b0);
      rdchk(pflow_pkg::REG_FLOW_LOW, 16'd2100, 1'b0);
      rdchk(pflow_pkg::REG_ALARM_FLAG, 16'h0000, 1'b0);
      @(posedge core_clk);
      velocity_enable <= 1'b0;
      settle();
      rdchk(pflow_pkg::REG_AIR_VELOCITY, 16'h0000, 1'b0);
      rdchk(pflow_pkg::REG_FLOW_LOW, 16'h0000, 1'b0);
      // pressure against span and alarm limits, then auto-tune
      @(posedge core_clk);
      pressure_pa <= 16'sd3000;
      settle();
      rdchk(pflow_pkg::REG_SPAN_FLAG, 16'h0001, 1'b0);
      rdchk(pflow_pkg::REG_ALARM_FLAG, 16'h0000, 1'b0);
      @(posedge core_clk);
      pressure_pa <= 16'sd6000;
      settle();
      rdchk(pflow_pkg::REG_ALARM_FLAG, 16'h0001, 1'b0);
      @(posedge core_clk);
      autotune_active <= 1'b1;
      settle();
      rdchk(pflow_pkg::REG_SPAN_FLAG, 16'h0000, 1'b0);
      rdchk(pflow_pkg::REG_ALARM_FLAG, 16'h0000, 1'b0);
      // fault pins: flag follows, indicator blinks
      @(posedge core_clk);
      fb_pin <= 1'b1;
      settle();
      rdchk(pflow_pkg::REG_FEEDBACK_LOST, 16'h0001, 1'b0);
      count_toggles(toggles);
      check(16'(toggles), 16'h0006);
      @(posedge core_clk);
      fb_pin <= 1'b0;
      sf_pin <= 1'b1;
      settle();
      rdchk(pflow_pkg::REG_FEEDBACK_LOST, 16'h0000, 1'b0);
      rdchk(pflow_pkg::REG_SENSOR_FAULT, 16'h0001, 1'b0);
      count_toggles(toggles);
      check(16'(toggles), 16'h0006);
      @(posedge core_clk);
      sf_pin <= 1'b0;
      settle();
      rdchk(pflow_pkg::REG_SENSOR_FAULT, 16'h0000, 1'b0);
      count_toggles(toggles);
      check(16'(toggles), 16'h0000);
      // reserved range reads zero and refuses writes; outside the map errors
      for (int a = 12; a <= 20; a++) begin
         host.wr(16'(a), ref_seen);
         check({15'h0000, ref_seen}, 16'h0001);
         rdchk(16'(a), 16'h0000, 1'b0);
      end
      rdchk(16'h0000, 16'h0000, 1'b1);
      rdchk(16'h0015, 16'h0000, 1'b1);
      end_of_test();
   end
endmodule
